//--- core/pcs_link_pkg.sv
package pcs_link_pkg;

  // ***************************************************************
  // Register map and field positions
  // ***************************************************************
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_LINK_STATUS = 5'h01;
  localparam int CTL_LOOPBACK_BIT = 14;
  localparam int CTL_AN_ENABLE_BIT = 12;
  localparam int CTL_ISOLATE_BIT = 10;
  localparam int CTL_AN_RESTART_BIT = 9;
  localparam int CTL_UNIDIR_BIT = 5;
  localparam int STS_AN_DONE_BIT = 5;
  localparam int STS_LINK_BIT = 2;
  localparam logic [15:0] CONTROL_RESET = 16'h1400;
  localparam logic [15:0] STATUS_FIXED = 16'h0108;

  // ***************************************************************
  // Timing constants
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_GOOD_CODES = 4;
  localparam int SYNC_BAD_CODES = 4;
  localparam int LINK_TIMER_US = 10;
  localparam int LINK_TIMER_CYCLES = LINK_TIMER_US * 1000 / CLK_PERIOD_NS;
  localparam int AN_TIMER_PERIODS = 3;

  // One GMII byte with its framing flags.
  typedef struct packed {
    logic en;
    logic er;
    logic [7:0] data;
  } gmii_beat_t;

  // Receive code group as seen from the transceiver.
  typedef struct packed {
    logic comma;
    logic codeErr;
    logic [7:0] data;
  } rx_code_t;

endpackage

//--- core/pcs_link_status_gating.sv
`timescale 1ns/1ps
// Operation
// R01: Block transmit while no link exists.
// R02: Unidirectional bit overrides transmit gating.
// R03: Start isolated until management clears isolate.
// R04: Isolated means no GMII data, outputs released.
// R05: Auto-negotiation done in status bit 5.
// R06: Interrupt output flags auto-negotiation completion.
// R07: Bit error restarts auto-negotiation from start.
// R08: Completion needs both ends auto-negotiating.
// R09: Link status in bit 2 and vector bit 1.
// R10: Vector bit 0 high on receive sync.
// R11: Signal detect low holds loss of sync.
// R12: Outside logic drives signal detect correctly.
// R13: Transceiver resets held until PLL lock.
// R14: Receive bit errors reach MAC as errors.
// R15: Internal loopback routes transmit to receive.
// R16: Management clock at most 2.5 MHz.
// R17: Status bits read-only and live.
module pcs_link_status_gating #(
  parameter int LINK_TIMER = pcs_link_pkg::LINK_TIMER_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic gmiiTxEn,
  input wire logic gmiiTxEr,
  input wire logic [7:0] gmiiTxData,
  output logic gmiiTxReady,
  output logic gmiiRxDv,
  output logic gmiiRxEr,
  output logic [7:0] gmiiRxData,
  output logic gmiiRxOe,
  input wire logic gmiiRxReady,
  output logic serTxValid,
  output logic [7:0] serTxData,
  input wire logic serRxComma,
  input wire logic serRxCodeErr,
  input wire logic [7:0] serRxData,
  input wire logic signalDetect,
  input wire logic pllLock,
  output logic mgtTxReset,
  output logic mgtRxReset,
  input wire logic partnerAnEnable,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic anInterrupt,
  output logic [1:0] linkState
);

  // ***************************************************************
  // Control register
  // ***************************************************************
  logic [15:0] control_ff, nxt_control;
  logic isolate, unidir, anEnable, loopback, anRestart;

  assign isolate = control_ff[pcs_link_pkg::CTL_ISOLATE_BIT];
  assign unidir = control_ff[pcs_link_pkg::CTL_UNIDIR_BIT];
  assign anEnable = control_ff[pcs_link_pkg::CTL_AN_ENABLE_BIT];
  assign loopback = control_ff[pcs_link_pkg::CTL_LOOPBACK_BIT];
  assign anRestart = regWrite && (regAddr == pcs_link_pkg::REG_CONTROL)
    && regWrData[pcs_link_pkg::CTL_AN_RESTART_BIT];

  // The restart bit self-clears, so it is never stored.
  always_comb
  begin
    nxt_control = control_ff;
    if (regWrite && (regAddr == pcs_link_pkg::REG_CONTROL))
    begin
      nxt_control = regWrData;
      nxt_control[pcs_link_pkg::CTL_AN_RESTART_BIT] = 1'b0;
    end
  end

  // Isolate is set at reset, so power-up leaves the GMII cut off.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      control_ff <= pcs_link_pkg::CONTROL_RESET; // R03
    end
    else
    begin
      control_ff <= nxt_control;
    end
  end

  // ***************************************************************
  // Transceiver reset and loopback routing
  // ***************************************************************
  pcs_link_pkg::rx_code_t rxCode;
  pcs_link_pkg::gmii_beat_t txBeat, bufBeat;
  logic bufValid, bufReady, txAllowed, txInValid;

  // Resets follow lock directly; a lost lock resets again at once.
  assign mgtTxReset = !pllLock; // R13
  assign mgtRxReset = !pllLock; // R13

  // Loopback feeds our own transmit bytes back as clean code groups.
  always_comb
  begin
    if (loopback) // R15
    begin
      rxCode.comma = !serTxValid;
      rxCode.codeErr = 1'b0;
      rxCode.data = serTxData;
    end
    else
    begin
      rxCode.comma = serRxComma;
      rxCode.codeErr = serRxCodeErr;
      rxCode.data = serRxData;
    end
  end

  // ***************************************************************
  // Receive synchronisation
  // ***************************************************************
  typedef enum logic [1:0] {SYNC_LOST, SYNC_ACQ, SYNC_OK} sync_state_t;
  sync_state_t sync_ff, nxt_sync;
  logic [2:0] goodCnt_ff, nxt_goodCnt;
  logic syncOk;

  assign syncOk = (sync_ff == SYNC_OK);

  // Commas build sync; repeated code errors tear it down.
  always_comb
  begin
    nxt_sync = sync_ff;
    nxt_goodCnt = goodCnt_ff;
    unique case (sync_ff)
      SYNC_LOST:
      begin
        nxt_goodCnt = 3'h0;
        if (rxCode.comma && !rxCode.codeErr)
        begin
          nxt_sync = SYNC_ACQ;
        end
      end
      SYNC_ACQ:
      begin
        if (rxCode.codeErr)
        begin
          nxt_sync = SYNC_LOST;
        end
        else if (goodCnt_ff == 3'(pcs_link_pkg::SYNC_GOOD_CODES - 1))
        begin
          nxt_sync = SYNC_OK;
          nxt_goodCnt = 3'h0;
        end
        else
        begin
          nxt_goodCnt = goodCnt_ff + 3'h1;
        end
      end
      SYNC_OK:
      begin
        if (rxCode.codeErr)
        begin
          nxt_goodCnt = goodCnt_ff + 3'h1;
          if (goodCnt_ff == 3'(pcs_link_pkg::SYNC_BAD_CODES - 1))
          begin
            nxt_sync = SYNC_LOST;
          end
        end
        else if (rxCode.comma)
        begin
          nxt_goodCnt = 3'h0;
        end
      end
    endcase
    // No light, or transceiver in reset, pins sync at loss.
    if (!signalDetect || !pllLock) // R11
    begin
      nxt_sync = SYNC_LOST;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sync_ff <= SYNC_LOST;
      goodCnt_ff <= 3'h0;
    end
    else
    begin
      sync_ff <= nxt_sync;
      goodCnt_ff <= nxt_goodCnt;
    end
  end

  // ***************************************************************
  // Auto-negotiation
  // ***************************************************************
  typedef enum logic [1:0] {AN_IDLE, AN_EXCHANGE, AN_DONE} an_state_t;
  an_state_t an_ff, nxt_an;
  logic [$clog2(LINK_TIMER+1)-1:0] timer_ff, nxt_timer;
  logic [1:0] periods_ff, nxt_periods;
  logic anDone, linkUp, anDoneDly_ff, nxt_anDoneDly;
  logic partnerAn;

  // In loopback the partner is ourselves.
  assign partnerAn = loopback ? anEnable : partnerAnEnable;
  assign anDone = (an_ff == AN_DONE);
  assign linkUp = syncOk && (!anEnable || anDone);

  // The exchange must run several link timer periods error-free.
  always_comb
  begin
    nxt_an = an_ff;
    nxt_timer = timer_ff;
    nxt_periods = periods_ff;
    unique case (an_ff)
      AN_IDLE:
      begin
        nxt_timer = '0;
        nxt_periods = 2'h0;
        if (anEnable && partnerAn && syncOk) // R08
        begin
          nxt_an = AN_EXCHANGE;
        end
      end
      AN_EXCHANGE:
      begin
        if (timer_ff == ($bits(timer_ff))'(LINK_TIMER - 1))
        begin
          nxt_timer = '0;
          nxt_periods = periods_ff + 2'h1;
          if (periods_ff == 2'(pcs_link_pkg::AN_TIMER_PERIODS - 1))
          begin
            nxt_an = AN_DONE;
          end
        end
        else
        begin
          nxt_timer = timer_ff + 1'b1;
        end
        // A bit error throws the exchange away.
        if (rxCode.codeErr) // R07
        begin
          nxt_an = AN_IDLE;
        end
      end
      AN_DONE:
      begin
        if (!syncOk)
        begin
          nxt_an = AN_IDLE;
        end
      end
    endcase
    if (!anEnable || !partnerAn || anRestart) // R08
    begin
      nxt_an = AN_IDLE;
    end
  end

  assign nxt_anDoneDly = anDone;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      an_ff <= AN_IDLE;
      timer_ff <= '0;
      periods_ff <= 2'h0;
      anDoneDly_ff <= 1'b0;
    end
    else
    begin
      an_ff <= nxt_an;
      timer_ff <= nxt_timer;
      periods_ff <= nxt_periods;
      anDoneDly_ff <= nxt_anDoneDly;
    end
  end

  // One-cycle pulse on the rising edge of completion.
  assign anInterrupt = anDone && !anDoneDly_ff; // R06
  assign linkState[0] = syncOk; // R10
  assign linkState[1] = linkUp; // R09

  // ***************************************************************
  // Register read path
  // ***************************************************************
  // Status is assembled live each read; writes to it are ignored.
  always_comb
  begin
    regRdData = 16'h0000;
    if (regRead && (regAddr == pcs_link_pkg::REG_CONTROL))
    begin
      regRdData = control_ff;
    end
    else if (regRead && (regAddr == pcs_link_pkg::REG_LINK_STATUS)) // R17
    begin
      regRdData = pcs_link_pkg::STATUS_FIXED;
      regRdData[pcs_link_pkg::STS_AN_DONE_BIT] = anDone; // R05
      regRdData[pcs_link_pkg::STS_LINK_BIT] = linkUp; // R09
    end
  end

  // ***************************************************************
  // Transmit path
  // ***************************************************************
  // Without a link nothing goes out unless unidirectional is set.
  assign txAllowed = !isolate && (linkUp || unidir); // R01 R02
  assign txInValid = gmiiTxEn && txAllowed; // R04
  assign gmiiTxReady = bufReady && txAllowed;
  assign txBeat.en = gmiiTxEn;
  assign txBeat.er = gmiiTxEr;
  assign txBeat.data = gmiiTxData;

  pcs_skid_buffer #(
    .WIDTH($bits(pcs_link_pkg::gmii_beat_t))
  ) pcs_skid_buffer_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .inValid(txInValid),
    .inReady(bufReady),
    .inData(txBeat),
    .outValid(bufValid),
    .outReady(1'b1),
    .outData(bufBeat)
  );

  assign serTxValid = bufValid;
  assign serTxData = bufValid ? bufBeat.data : 8'hBC;

  // ***************************************************************
  // Receive path
  // ***************************************************************
  logic rxDv_ff, nxt_rxDv, rxEr_ff, nxt_rxEr;
  logic [7:0] rxData_ff, nxt_rxData;
  logic rxPass;

  // Isolation or a stalled client drops the byte rather than hold it.
  assign rxPass = linkUp && !isolate && gmiiRxReady; // R04

  always_comb
  begin
    nxt_rxDv = rxPass && !rxCode.comma;
    nxt_rxEr = rxPass && rxCode.codeErr; // R14
    nxt_rxData = rxPass ? rxCode.data : 8'h00;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rxDv_ff <= 1'b0;
      rxEr_ff <= 1'b0;
      rxData_ff <= 8'h00;
    end
    else
    begin
      rxDv_ff <= nxt_rxDv;
      rxEr_ff <= nxt_rxEr;
      rxData_ff <= nxt_rxData;
    end
  end

  assign gmiiRxDv = rxDv_ff;
  assign gmiiRxEr = rxEr_ff;
  assign gmiiRxData = rxData_ff;
  // Released outputs model the electrical disconnect when isolated.
  assign gmiiRxOe = !isolate; // R04

endmodule

//--- core/pcs_skid_buffer.sv
`timescale 1ns/1ps
module pcs_skid_buffer #(
  parameter int WIDTH = 10
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  // ***************************************************************
  // Two-entry storage
  // ***************************************************************
  logic [WIDTH-1:0] mem_ff [2];
  logic [WIDTH-1:0] nxt_mem [2];
  logic rdPtr_ff, nxt_rdPtr, wrPtr_ff, nxt_wrPtr;
  logic [1:0] count_ff, nxt_count;
  logic doPush, doPop;

  // Ready is honest: it falls only when both entries are occupied.
  assign inReady = (count_ff != 2'h2);
  assign outValid = (count_ff != 2'h0);
  assign outData = mem_ff[rdPtr_ff];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // Pointer and count update.
  always_comb
  begin
    nxt_mem = mem_ff;
    nxt_wrPtr = wrPtr_ff;
    nxt_rdPtr = rdPtr_ff;
    nxt_count = count_ff;
    if (doPush)
    begin
      nxt_mem[wrPtr_ff] = inData;
      nxt_wrPtr = ~wrPtr_ff;
    end
    if (doPop)
    begin
      nxt_rdPtr = ~rdPtr_ff;
    end
    if (doPush && !doPop)
    begin
      nxt_count = count_ff + 2'h1;
    end
    else if (doPop && !doPush)
    begin
      nxt_count = count_ff - 2'h1;
    end
  end

  // Registers.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wrPtr_ff <= 1'b0;
      rdPtr_ff <= 1'b0;
      count_ff <= 2'h0;
    end
    else
    begin
      mem_ff <= nxt_mem;
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end

endmodule

//--- tb/pcs_link_asserts.sv
`timescale 1ns/1ps
module pcs_link_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic gmiiTxReady,
  input wire logic gmiiRxDv,
  input wire logic gmiiRxOe,
  input wire logic signalDetect,
  input wire logic pllLock,
  input wire logic mgtTxReset,
  input wire logic mgtRxReset,
  input wire logic regRead,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regRdData,
  input wire logic anInterrupt,
  input wire logic [1:0] linkState
);
  // ****************************************
  // Properties
  // ****************************************
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  property p_mgt_rst;
    mgtTxReset == !pllLock && mgtRxReset == !pllLock;
  endproperty
  a_mgt_rst: assert property (p_mgt_rst)
    else $error("transceiver reset does not follow lock");

  property p_iso;
    !gmiiRxOe |-> !gmiiRxDv && !gmiiTxReady;
  endproperty
  a_iso: assert property (p_iso)
    else $error("traffic while isolated");

  // Three cycles leave room for the registered sync state.
  property p_sigdet;
    !signalDetect [*3] |-> !linkState[0];
  endproperty
  a_sigdet: assert property (p_sigdet)
    else $error("sync held with signal detect low");

  property p_link_sync;
    linkState[1] |-> linkState[0];
  endproperty
  a_link_sync: assert property (p_link_sync)
    else $error("link without sync");

  property p_lstat;
    regRead && regAddr == 5'h01 |-> regRdData[2] == linkState[1];
  endproperty
  a_lstat: assert property (p_lstat)
    else $error("status link bit differs from vector");

  property p_irq_pulse;
    anInterrupt |=> !anInterrupt;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("completion pulse too long");

  property p_irq_sync;
    anInterrupt |-> linkState[0];
  endproperty
  a_irq_sync: assert property (p_irq_sync)
    else $error("completion without sync");

  property p_fixed;
    regRead && regAddr == 5'h01 |->
      (regRdData & 16'hFFDB) == pcs_link_pkg::STATUS_FIXED;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed status bits wrong");

  c_an: cover property (anInterrupt);
  c_tx: cover property (linkState[1] && gmiiTxReady);
  c_done: cover property (regRead && regRdData[5]);
endmodule

bind pcs_link_status_gating pcs_link_asserts pcs_link_asserts_i (
  .ref_clk, .reset, .gmiiTxReady, .gmiiRxDv, .gmiiRxOe, .signalDetect,
  .pllLock, .mgtTxReset, .mgtRxReset, .regRead, .regAddr, .regRdData,
  .anInterrupt, .linkState
);

//--- tb/pcs_link_partner.sv
`timescale 1ns/1ps
module pcs_link_partner (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic errReq,
  output logic serRxComma,
  output logic serRxCodeErr,
  output logic [7:0] serRxData,
  output logic partnerAnEnable
);
  logic phase;

  // The far end always negotiates, so completion rests on the core.
  assign partnerAnEnable = 1'b1;

  // Idle alternates comma and data; an error request spoils one code
  // group, with inverted data so that nothing stale is seen.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      phase <= 1'b0;
      serRxComma <= 1'b0;
      serRxCodeErr <= 1'b0;
      serRxData <= 8'h00;
    end
    else
    begin
      phase <= ~phase;
      serRxComma <= ~phase & ~errReq;
      serRxCodeErr <= errReq;
      serRxData <= (phase ? 8'h50 : 8'hBC) ^ {8{errReq}};
    end
  end
endmodule

//--- tb/pcs_link_status_gating_bench.sv
`timescale 1ns/1ps
module pcs_link_status_gating_bench;
  logic ref_clk, reset, gmiiTxEn, gmiiTxEr, gmiiTxReady, gmiiRxDv;
  logic gmiiRxEr, gmiiRxOe, gmiiRxReady, serTxValid, serRxComma;
  logic serRxCodeErr, signalDetect, pllLock, mgtTxReset, mgtRxReset;
  logic partnerAnEnable, regWrite, regRead, anInterrupt, errReq, hit;
  logic [7:0] gmiiTxData, gmiiRxData, serTxData, serRxData;
  logic [4:0] regAddr;
  logic [15:0] regWrData, regRdData;
  logic [1:0] linkState;
  int error_cnt, cmp_count, cyc;

  // Short link timer keeps negotiation to a few dozen cycles.
  pcs_link_status_gating #(.LINK_TIMER(10)) pcs_link_status_gating_i (
    .ref_clk, .reset, .gmiiTxEn, .gmiiTxEr, .gmiiTxData, .gmiiTxReady,
    .gmiiRxDv, .gmiiRxEr, .gmiiRxData, .gmiiRxOe, .gmiiRxReady,
    .serTxValid, .serTxData, .serRxComma, .serRxCodeErr, .serRxData,
    .signalDetect, .pllLock, .mgtTxReset, .mgtRxReset, .partnerAnEnable,
    .regWrite, .regRead, .regAddr, .regWrData, .regRdData, .anInterrupt,
    .linkState
  );

  pcs_link_partner pcs_link_partner_i (
    .ref_clk, .reset, .errReq, .serRxComma, .serRxCodeErr, .serRxData,
    .partnerAnEnable
  );

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  // Free-running core clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // The tests need a few hundred cycles; a hang ends the run.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      finish_test;
    end
  end

  // Compare one value, four-state, and count it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Register write, taken at the edge that sees the strobe.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask

  // Read data is combinational, so it is sampled mid-cycle.
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(negedge ref_clk);
    chk(regRdData, exp);
    @(posedge ref_clk);
    regRead <= 1'b0;
  endtask

  // Offer one byte and look at the line half a cycle after the edge that takes it.
  task automatic send(input logic [7:0] d, input logic [15:0] exp);
    @(posedge ref_clk);
    gmiiTxEn <= 1'b1;
    gmiiTxData <= d;
    @(posedge ref_clk);
    gmiiTxEn <= 1'b0;
    @(negedge ref_clk);
    chk({7'h00, serTxValid, serTxData}, exp);
  endtask

  // Bounded wait for completion pulse or for sync.
  task automatic waitHi(input bit irq);
    int i;
    logic s;
    i = 0;
    s = 1'b0;
    while (s !== 1'b1 && i < 300)
    begin
      @(negedge ref_clk);
      s = irq ? anInterrupt : linkState[0];
      i++;
    end
    chk({15'h0000, s}, 16'h0001);
  endtask

  task automatic finish_test;
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  // Reset, isolation, gating, sync, negotiation, errors, loopback.
  initial
  begin
    {gmiiTxEn, gmiiTxEr, regWrite, regRead, errReq, pllLock} = '0;
    {gmiiTxData, regAddr, regWrData} = '0;
    signalDetect = 1'b0;
    gmiiRxReady = 1'b1;
    reset = 1'b1;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk({14'h0000, mgtTxReset, mgtRxReset}, 16'h0003);
    @(posedge ref_clk);
    pllLock <= 1'b1;
    @(negedge ref_clk);
    chk({14'h0000, mgtTxReset, mgtRxReset}, 16'h0000);
    chk({15'h0000, gmiiRxOe}, 16'h0000);
    rd(5'h00, pcs_link_pkg::CONTROL_RESET);
    rd(5'h01, pcs_link_pkg::STATUS_FIXED);
    rd(5'h1F, 16'h0000);
    wr(5'h01, 16'hFFFF);
    rd(5'h01, pcs_link_pkg::STATUS_FIXED);
    $display("test reset done");
    wr(5'h00, 16'h1420);
    send(8'hA5, 16'h00BC);
    wr(5'h00, 16'h1000);
    @(negedge ref_clk);
    chk({14'h0000, gmiiRxOe, gmiiTxReady}, 16'h0002);
    send(8'hA5, 16'h00BC);
    wr(5'h00, 16'h1020);
    send(8'hA5, 16'h01A5);
    send(8'h5A, 16'h015A);
    wr(5'h00, 16'h1000);
    $display("test gating done");
    repeat (20) @(negedge ref_clk);
    chk({14'h0000, linkState}, 16'h0000);
    @(posedge ref_clk);
    signalDetect <= 1'b1;
    waitHi(1'b0);
    // Sync alone is no link while negotiation is still running.
    chk({14'h0000, linkState}, 16'h0001);
    rd(5'h01, pcs_link_pkg::STATUS_FIXED);
    send(8'h3C, 16'h00BC);
    waitHi(1'b1);
    chk({14'h0000, linkState}, 16'h0003);
    rd(5'h01, pcs_link_pkg::STATUS_FIXED | 16'h0024);
    send(8'h3C, 16'h013C);
    $display("test link done");
    @(posedge ref_clk);
    errReq <= 1'b1;
    @(posedge ref_clk);
    errReq <= 1'b0;
    hit = 1'b0;
    repeat (4)
    begin
      @(negedge ref_clk);
      hit = hit | (gmiiRxEr === 1'b1);
    end
    chk({15'h0000, hit}, 16'h0001);
    // Restart, then spoil one code group part way through the exchange;
    // without a second restart it would be done before the read.
    wr(5'h00, 16'h1200);
    repeat (10) @(posedge ref_clk);
    errReq <= 1'b1;
    @(posedge ref_clk);
    errReq <= 1'b0;
    repeat (25) @(negedge ref_clk);
    rd(5'h01, pcs_link_pkg::STATUS_FIXED);
    waitHi(1'b1);
    $display("test error done");
    wr(5'h00, 16'h5200);
    waitHi(1'b1);
    wr(5'h00, 16'h1000);
    @(posedge ref_clk);
    signalDetect <= 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({13'h0000, linkState, gmiiTxReady}, 16'h0000);
    $display("test loopback done");
    finish_test;
  end
endmodule
